// ==== src/srpll_dev.sv ====
// Purpose: Per-port SerDes PLL configuration registers and core-clock link timers.
// Assumes: 125 MHz SerDes reference; register access over the maintenance path.
// Notes:   PLL registers are volatile against hard reset and port power-down.
// Behaviour
// - PLL powers up x20, reprogram gives x25.
// - Hard reset or power-down restores PLL defaults.
// - Boot writes land while SerDes held reset.
// - Pin code 10 gives 3.125 reprogrammed, 2.5 if not; other codes 1.25.
// - Host starts only after its link is up.
// - Step one puts MAC in soft reset.
// - Step two sets the init-override bit.
// - Steps three-five shut lanes in order.
// - Steps six-seven power off, gate PLL clock.
// - Step eight writes new multiplier, then load.
// - Step nine removes PLL clock gating.
// - Step ten pulses active-low SerDes reset.
// - Step eleven powers PLL on again.
// - Steps twelve-fourteen reopen lanes in order.
// - Step fifteen releases MAC soft reset.
// - Link time-out is 32 cycles times count.
// - Silence timer fixed, scales with core clock.
// - Silence done after 120 us in SILENT.
// - Discovery done after about 118 ms.
// - Discovery is prescale times 131071 cycles.
// - Discovery timer used only in four-lane mode.
// - Two speed pins select lane rate.
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "srpll_params.svh"
module srpll_dev #(
  parameter int DISC_BASE_CYC = `SRPLL_DISC_BASE
) (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Maintenance register access.
  srpll_if.dev            mif,
  // Port control inputs.
  input  wire logic       hard_reset_n,
  input  wire logic       port_power_down,
  input  wire logic       boot_active,
  input  wire logic [1:0] port_speed_pins,
  input  wire logic       four_lane_mode,
  // Link state machine timer handshakes.
  input  wire logic       silence_timer_en,
  input  wire logic       in_silent,
  input  wire logic       discovery_timer_en,
  input  wire logic       in_discovery,
  input  wire logic       link_wait,
  // SerDes controls.
  output logic            serdes_reset_n_ff,
  output logic            pll_power_on_ff,
  output logic            pll_clock_gate_ff,
  output logic            pll_mult_x25_ff,
  output logic [11:0]     lane_tx_en_ff,
  output logic [3:0]      lane_rx_en_ff,
  output logic [3:0]      receive_pll_power_on_ff,
  output logic            mac_soft_reset_ff,
  output logic [1:0]      lane_rate_ff,
  // Timer results.
  output logic            silence_timer_done,
  output logic            discovery_timer_done,
  output logic            link_timeout
);
  import srpll_pkg::*;

  srpll_word_t  lane_cfg_ff [4];
  srpll_word_t  gbl_ff;
  srpll_word_t  pllmul_ff;
  srpll_word_t  mac_ff;
  logic [23:0]  link_timeout_count_ff;
  logic [3:0]   disc_prescale_ff;
  logic         ack_ff;
  srpll_word_t  rdata_ff;
  logic         wr_hit;
  logic         pll_restore;
  logic         sw_ctl;
  logic         nxt_rstn;
  logic         nxt_pwr;
  logic         nxt_gate;
  srpll_word_t  rd_val;
  srpll_word_t  status_val;

  assign wr_hit      = mif.maint_req && !ack_ff && mif.maint_wr;
  assign pll_restore = !hard_reset_n || port_power_down;
  assign sw_ctl      = gbl_ff[`SRPLL_GBL_OVR_BIT];

  // One-cycle acknowledge for each held request; the host waits on it.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= mif.maint_req && !ack_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= '0;
    end else if (mif.maint_req && !ack_ff && !mif.maint_wr) begin
      rdata_ff <= rd_val;
    end
  end

  assign mif.maint_ack   = ack_ff;
  assign mif.maint_rdata = rdata_ff;

  // PLL control registers, volatile against hard reset and power-down.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        lane_cfg_ff[i] <= `SRPLL_LANE_RST;
      end
      gbl_ff    <= `SRPLL_GBL_RST;
      pllmul_ff <= `SRPLL_PLLMUL_RST;
      mac_ff    <= `SRPLL_MAC_RST;
    end else if (pll_restore) begin
      for (int i = 0; i < 4; i++) begin
        lane_cfg_ff[i] <= `SRPLL_LANE_RST;
      end
      gbl_ff    <= `SRPLL_GBL_RST;
      pllmul_ff <= `SRPLL_PLLMUL_RST;
      mac_ff    <= `SRPLL_MAC_RST;
    end else if (wr_hit) begin
      unique case (mif.maint_addr)
        `SRPLL_OFS_LANE0: lane_cfg_ff[0] <= mif.maint_wdata;
        `SRPLL_OFS_LANE1: lane_cfg_ff[1] <= mif.maint_wdata;
        `SRPLL_OFS_LANE2: lane_cfg_ff[2] <= mif.maint_wdata;
        `SRPLL_OFS_LANE3: lane_cfg_ff[3] <= mif.maint_wdata;
        `SRPLL_OFS_GLOBAL: gbl_ff <= mif.maint_wdata;
        `SRPLL_OFS_PLLMUL: pllmul_ff <= mif.maint_wdata;
        `SRPLL_OFS_MAC: mac_ff <= mif.maint_wdata;
        default: begin
        end
      endcase
    end
  end

  // Timer settings are not part of the PLL set and survive power-down.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      link_timeout_count_ff <= 24'hFFFFFF;
      disc_prescale_ff      <= `SRPLL_DISC_RST;
    end else if (wr_hit && mif.maint_addr == `SRPLL_OFS_LINKTO) begin
      link_timeout_count_ff <= mif.maint_wdata[23:0];
    end else if (wr_hit && mif.maint_addr == `SRPLL_OFS_DISC) begin
      disc_prescale_ff <= mif.maint_wdata[3:0];
    end
  end

  assign status_val = {24'h000000, silence_timer_done, discovery_timer_done, link_timeout,
                       serdes_reset_n_ff, lane_rate_ff, pll_power_on_ff, pll_mult_x25_ff};

  always_comb begin
    unique case (mif.maint_addr)
      `SRPLL_OFS_LANE0: rd_val = lane_cfg_ff[0];
      `SRPLL_OFS_LANE1: rd_val = lane_cfg_ff[1];
      `SRPLL_OFS_LANE2: rd_val = lane_cfg_ff[2];
      `SRPLL_OFS_LANE3: rd_val = lane_cfg_ff[3];
      `SRPLL_OFS_GLOBAL: rd_val = gbl_ff;
      `SRPLL_OFS_PLLMUL: rd_val = pllmul_ff;
      `SRPLL_OFS_MAC: rd_val = mac_ff;
      `SRPLL_OFS_LINKTO: rd_val = {8'h00, link_timeout_count_ff};
      `SRPLL_OFS_DISC: rd_val = {28'h0000000, disc_prescale_ff};
      `SRPLL_OFS_STATUS: rd_val = status_val;
      default: rd_val = '0;
    endcase
  end

  // Without override the hardware runs the PLL; with it, software bits rule.
  always_comb begin
    nxt_rstn = !boot_active;
    nxt_pwr  = 1'b1;
    nxt_gate = 1'b0;
    if (sw_ctl) begin
      nxt_rstn = !boot_active && gbl_ff[`SRPLL_GBL_RSTN_BIT];
      nxt_pwr  = gbl_ff[`SRPLL_GBL_PWR_BIT];
      nxt_gate = gbl_ff[`SRPLL_GBL_GATE_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      serdes_reset_n_ff <= 1'b0;
      pll_power_on_ff   <= 1'b0;
      pll_clock_gate_ff <= 1'b0;
    end else begin
      serdes_reset_n_ff <= nxt_rstn && !pll_restore;
      pll_power_on_ff   <= nxt_pwr && !pll_restore;
      pll_clock_gate_ff <= nxt_gate;
    end
  end

  // The multiplier reaches the PLL only while the SerDes is held in reset or the clock is gated.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pll_mult_x25_ff <= 1'b0;
    end else if (pll_restore) begin
      pll_mult_x25_ff <= 1'b0;
    end else if (!nxt_rstn || (nxt_gate && gbl_ff[`SRPLL_GBL_LOAD_BIT])) begin
      pll_mult_x25_ff <= pllmul_ff[`SRPLL_MUL_X25_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lane_tx_en_ff           <= '0;
      lane_rx_en_ff           <= '0;
      receive_pll_power_on_ff <= '0;
      mac_soft_reset_ff       <= 1'b1;
    end else begin
      for (int i = 0; i < 4; i++) begin
        lane_tx_en_ff[3*i +: 3]    <= lane_cfg_ff[i][`SRPLL_LANE_TXEN_LSB +: 3];
        lane_rx_en_ff[i]           <= lane_cfg_ff[i][`SRPLL_LANE_RXEN_BIT];
        receive_pll_power_on_ff[i] <= lane_cfg_ff[i][`SRPLL_LANE_RXPLL_BIT];
      end
      mac_soft_reset_ff <= mac_ff[`SRPLL_MAC_SRST_BIT] || pll_restore;
    end
  end

  // Rate reported for a 125 MHz reference; x25 lifts the top code to 3.125.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lane_rate_ff <= `SRPLL_RATE_1G25;
    end else if (port_speed_pins == 2'b10) begin
      lane_rate_ff <= pll_mult_x25_ff ? `SRPLL_RATE_3G125 : `SRPLL_RATE_2G5;
    end else if (port_speed_pins == 2'b01) begin
      lane_rate_ff <= `SRPLL_RATE_1G25;
    end else begin
      lane_rate_ff <= `SRPLL_RATE_1G25;
    end
  end

  srpll_timer #(.PW(1), .CW(11)) u_silence (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .run      (silence_timer_en && in_silent),
    .pre_last (1'b0),
    .limit    (11'(`SRPLL_SILENCE_CYC)),
    .done_ff  (silence_timer_done)
  );

  srpll_timer #(.PW(17), .CW(4)) u_discovery (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .run      (discovery_timer_en && in_discovery && four_lane_mode),
    .pre_last (17'(DISC_BASE_CYC - 1)),
    .limit    (disc_prescale_ff),
    .done_ff  (discovery_timer_done)
  );

  srpll_timer #(.PW(5), .CW(24)) u_link_timeout (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .run      (link_wait),
    .pre_last (5'(`SRPLL_LINKTO_PRE - 1)),
    .limit    (link_timeout_count_ff),
    .done_ff  (link_timeout)
  );
endmodule

// ==== src/srpll_params.svh ====
// Purpose: Offsets, field positions, reset values and timing counts for the SerDes PLL block.
// Assumes: 10 MHz core clock, 32-bit maintenance data.
// Notes:   Definitions only.
`ifndef SRPLL_PARAMS_SVH
`define SRPLL_PARAMS_SVH

`define SRPLL_AW            20
`define SRPLL_OFS_LANE0     20'h132B0
`define SRPLL_OFS_LANE1     20'h132B4
`define SRPLL_OFS_LANE2     20'h132B8
`define SRPLL_OFS_LANE3     20'h132BC
`define SRPLL_OFS_GLOBAL    20'h132C0
`define SRPLL_OFS_PLLMUL    20'h132C4
`define SRPLL_OFS_MAC       20'h132C8
`define SRPLL_OFS_LINKTO    20'h13320
`define SRPLL_OFS_DISC      20'h13324
`define SRPLL_OFS_STATUS    20'h13328

`define SRPLL_GBL_RSTN_BIT  31
`define SRPLL_GBL_PWR_BIT   7
`define SRPLL_GBL_GATE_BIT  6
`define SRPLL_GBL_OVR_BIT   2
`define SRPLL_GBL_LOAD_BIT  0
`define SRPLL_MUL_X25_BIT   0
`define SRPLL_LANE_RXEN_BIT 14
`define SRPLL_LANE_RXPLL_BIT 15
`define SRPLL_LANE_TXEN_LSB 20
`define SRPLL_MAC_SRST_BIT  4

`define SRPLL_LANE_RST      32'h203CE513
`define SRPLL_GBL_RST       32'hCA060081
`define SRPLL_PLLMUL_RST    32'h002C0544
`define SRPLL_MAC_RST       32'h7FFF0002
`define SRPLL_DISC_RST      4'h9

`define SRPLL_V_MAC_SRST    32'h7FFF0012
`define SRPLL_V_GBL_OVR     32'hCA060084
`define SRPLL_V_LANE_NORX   32'h203CA513
`define SRPLL_V_LANE_NOPLL  32'h203C2513
`define SRPLL_V_LANE_OFF    32'h200C2513
`define SRPLL_V_GBL_PWROFF  32'hCA060004
`define SRPLL_V_GBL_GATE    32'hCA060044
`define SRPLL_V_PLLMUL_X25  32'h002C0545
`define SRPLL_V_GBL_LOAD    32'hCA060045
`define SRPLL_V_GBL_UNGATE  32'hCA060005
`define SRPLL_V_GBL_SRST    32'h4A060005
`define SRPLL_V_GBL_PWRON   32'hCA060085
`define SRPLL_V_LANE_ON     32'h203CE513
`define SRPLL_V_MAC_RUN     32'h7FFF0002
`define SRPLL_SEQ_LEN       6'd35

`define SRPLL_RATE_1G25     2'b00
`define SRPLL_RATE_2G5      2'b01
`define SRPLL_RATE_3G125    2'b10

`define SRPLL_CLK_MHZ       10
`define SRPLL_SILENCE_US    120
`define SRPLL_SILENCE_CYC   (`SRPLL_SILENCE_US * `SRPLL_CLK_MHZ)
`define SRPLL_LINKTO_PRE    32
`define SRPLL_DISC_BASE     131071

`define SRPLL_HOFS_CTRL     32'h00000000
`define SRPLL_HOFS_STATUS   32'h00000004
`endif

// ==== src/srpll_pkg.sv ====
// Purpose: Types shared by both ends of the SerDes PLL block.
// Assumes: Constants live in srpll_params.svh.
// Notes:   None.
package srpll_pkg;
  typedef logic [19:0] srpll_addr_t;
  typedef logic [31:0] srpll_word_t;
  typedef enum logic [1:0] {SRPLL_H_IDLE, SRPLL_H_REQ, SRPLL_H_GAP} srpll_hstate_e;
endpackage

// ==== src/srpll_if.sv ====
// Purpose: Maintenance write/read path between configuring host and device.
// Assumes: Request held until acknowledge.
// Notes:   No clocking block.
`timescale 1ns/100ps
interface srpll_if;
  import srpll_pkg::*;
  logic        maint_req;
  logic        maint_wr;
  srpll_addr_t maint_addr;
  srpll_word_t maint_wdata;
  logic        maint_ack;
  srpll_word_t maint_rdata;

  modport dev  (input maint_req, maint_wr, maint_addr, maint_wdata,
                output maint_ack, maint_rdata);
  modport host (output maint_req, maint_wr, maint_addr, maint_wdata,
                input maint_ack, maint_rdata);
endinterface

// ==== src/srpll_timer.sv ====
// Purpose: Prescaled event timer with a registered done flag.
// Assumes: Prescaler and count restart whenever run drops.
// Notes:   Done rises after (PRE_LAST+1)*limit cycles of continuous run.
`timescale 1ns/100ps
module srpll_timer #(
  parameter int PW = 17,
  parameter int CW = 24
) (
  // Clock and reset.
  input  wire logic          clk_sys,
  input  wire logic          arst_n,
  // Control.
  input  wire logic          run,
  input  wire logic [PW-1:0] pre_last,
  input  wire logic [CW-1:0] limit,
  // Result.
  output logic               done_ff
);
  logic [PW-1:0] pre_ff;
  logic [CW-1:0] cnt_ff;
  logic          tick;

  assign tick = (pre_ff == pre_last);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pre_ff <= '0;
    end else if (!run || tick) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
    end else if (!run) begin
      cnt_ff <= '0;
    end else if (tick && cnt_ff != limit) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Done falls as soon as run is withdrawn or the state is left.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= run && (cnt_ff == limit);
    end
  end
endmodule

// ==== src/srpll_host.sv ====
// Purpose: Host sequencer that reprograms a port PLL to x25 over maintenance writes.
// Assumes: Software reaches the command registers over AHB-Lite, zero wait states.
// Notes:   Each write waits for its acknowledge before the next is issued.
`timescale 1ns/100ps
`include "srpll_params.svh"
module srpll_host (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Maintenance path to the device.
  srpll_if.host            mif,
  // Own link state.
  input  wire logic        link_ready,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);
  import srpll_pkg::*;

  srpll_hstate_e state_ff;
  logic [5:0]    idx_ff;
  logic          req_ff;
  srpll_addr_t   addr_ff;
  srpll_word_t   wdata_ff;
  logic          busy_ff;
  logic          done_ff;
  logic          refused_ff;
  logic          wpend_ff;
  logic [31:0]   ahb_addr_ff;
  logic [31:0]   rdata_ff;
  logic          start;
  srpll_addr_t   seq_addr;
  srpll_word_t   seq_data;

  function automatic srpll_addr_t lane_addr(input logic [5:0] i);
    lane_addr = `SRPLL_OFS_LANE0 + {16'h0000, i[1:0], 2'b00};
  endfunction

  // Fifteen steps, lane steps unrolled over the four lanes, strictly in order.
  always_comb begin
    seq_addr = `SRPLL_OFS_GLOBAL;
    seq_data = `SRPLL_V_GBL_UNGATE;
    if (idx_ff == 6'd0) begin
      seq_addr = `SRPLL_OFS_MAC;
      seq_data = `SRPLL_V_MAC_SRST;
    end else if (idx_ff == 6'd1) begin
      seq_data = `SRPLL_V_GBL_OVR;
    end else if (idx_ff < 6'd14) begin
      seq_addr = lane_addr(idx_ff - 6'd2);
      seq_data = (idx_ff < 6'd6) ? `SRPLL_V_LANE_NORX :
                 (idx_ff < 6'd10) ? `SRPLL_V_LANE_NOPLL : `SRPLL_V_LANE_OFF;
    end else if (idx_ff == 6'd14) begin
      seq_data = `SRPLL_V_GBL_PWROFF;
    end else if (idx_ff == 6'd15) begin
      seq_data = `SRPLL_V_GBL_GATE;
    end else if (idx_ff == 6'd16) begin
      seq_addr = `SRPLL_OFS_PLLMUL;
      seq_data = `SRPLL_V_PLLMUL_X25;
    end else if (idx_ff == 6'd17) begin
      seq_data = `SRPLL_V_GBL_LOAD;
    end else if (idx_ff == 6'd18) begin
      seq_data = `SRPLL_V_GBL_UNGATE;
    end else if (idx_ff == 6'd19) begin
      seq_data = `SRPLL_V_GBL_SRST;
    end else if (idx_ff == 6'd20) begin
      seq_data = `SRPLL_V_GBL_UNGATE;
    end else if (idx_ff == 6'd21) begin
      seq_data = `SRPLL_V_GBL_PWRON;
    end else if (idx_ff < 6'd34) begin
      seq_addr = lane_addr(idx_ff - 6'd22);
      seq_data = (idx_ff < 6'd26) ? `SRPLL_V_LANE_NOPLL :
                 (idx_ff < 6'd30) ? `SRPLL_V_LANE_NORX : `SRPLL_V_LANE_ON;
    end else begin
      seq_addr = `SRPLL_OFS_MAC;
      seq_data = `SRPLL_V_MAC_RUN;
    end
  end

  // AHB-Lite slave: address phase captured, data phase applied next cycle.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wpend_ff    <= 1'b0;
      ahb_addr_ff <= '0;
      rdata_ff    <= '0;
    end else begin
      wpend_ff <= hsel && htrans[1] && hready && hwrite;
      if (hsel && htrans[1] && hready) begin
        ahb_addr_ff <= haddr;
        if (haddr == `SRPLL_HOFS_STATUS) begin
          rdata_ff <= {16'h0000, 2'b00, idx_ff, 5'b00000, refused_ff, done_ff, busy_ff};
        end else begin
          rdata_ff <= '0;
        end
      end
    end
  end

  assign start     = wpend_ff && ahb_addr_ff == `SRPLL_HOFS_CTRL && hwdata[0];
  assign hreadyout = 1'b1;
  assign hrdata    = rdata_ff;
  assign hresp     = 1'b0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff   <= SRPLL_H_IDLE;
      idx_ff     <= '0;
      req_ff     <= 1'b0;
      addr_ff    <= '0;
      wdata_ff   <= '0;
      busy_ff    <= 1'b0;
      done_ff    <= 1'b0;
      refused_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        SRPLL_H_IDLE: begin
          if (start && link_ready) begin
            state_ff   <= SRPLL_H_REQ;
            idx_ff     <= '0;
            busy_ff    <= 1'b1;
            done_ff    <= 1'b0;
            refused_ff <= 1'b0;
          end else if (start) begin
            refused_ff <= 1'b1;
          end
        end
        SRPLL_H_REQ: begin
          req_ff   <= 1'b1;
          addr_ff  <= seq_addr;
          wdata_ff <= seq_data;
          state_ff <= SRPLL_H_GAP;
        end
        SRPLL_H_GAP: begin
          if (mif.maint_ack) begin
            req_ff <= 1'b0;
            if (idx_ff == `SRPLL_SEQ_LEN - 6'd1) begin
              state_ff <= SRPLL_H_IDLE;
              busy_ff  <= 1'b0;
              done_ff  <= 1'b1;
            end else begin
              idx_ff   <= idx_ff + 6'd1;
              state_ff <= SRPLL_H_REQ;
            end
          end
        end
      endcase
    end
  end

  assign mif.maint_req   = req_ff;
  assign mif.maint_wr    = 1'b1;
  assign mif.maint_addr  = addr_ff;
  assign mif.maint_wdata = wdata_ff;
endmodule

// ==== tb/srpll_properties.sv ====
// Purpose: Concurrent checks on the maintenance path between host and device.
// Assumes: One clock domain; the acknowledge is a one-cycle pulse.
// Notes:   Instantiated in tb beside the interface that joins the two ends.
`timescale 1ns/100ps
`include "srpll_params.svh"
module srpll_properties (
  // Clock and reset.
  input wire logic                   clk_sys,
  input wire logic                   arst_n,
  // Maintenance path.
  input wire logic                   maint_req,
  input wire logic                   maint_wr,
  input wire srpll_pkg::srpll_addr_t maint_addr,
  input wire srpll_pkg::srpll_word_t maint_wdata,
  input wire logic                   maint_ack,
  input wire srpll_pkg::srpll_word_t maint_rdata
);
  import srpll_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_ack_next;
    maint_req && !maint_ack |=> maint_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_end;
    maint_ack |=> !maint_ack && !maint_req;
  endproperty
  a_ack_end: assert property (p_ack_end) else $error("ack or req lingers");
  property p_hold;
    maint_req && !maint_ack |=> maint_req && $stable(maint_addr) && $stable(maint_wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed early");
  property p_write_only;
    maint_req |-> maint_wr;
  endproperty
  a_write_only: assert property (p_write_only) else $error("read issued");
  property p_mac_then_ovr;
    maint_ack && maint_wdata == `SRPLL_V_MAC_SRST |=> ##[1:4] ($rose(maint_req)
      && maint_addr == `SRPLL_OFS_GLOBAL && maint_wdata == `SRPLL_V_GBL_OVR);
  endproperty
  a_mac_then_ovr: assert property (p_mac_then_ovr) else $error("step two");
  property p_mul_then_load;
    maint_ack && maint_addr == `SRPLL_OFS_PLLMUL |=> ##[1:4] ($rose(maint_req)
      && maint_addr == `SRPLL_OFS_GLOBAL && maint_wdata == `SRPLL_V_GBL_LOAD);
  endproperty
  a_mul_then_load: assert property (p_mul_then_load) else $error("load step");
  property p_rst_pulse;
    maint_ack && maint_wdata == `SRPLL_V_GBL_SRST |=> ##[1:4] ($rose(maint_req)
      && maint_addr == `SRPLL_OFS_GLOBAL && maint_wdata == `SRPLL_V_GBL_UNGATE);
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse");
  property p_pwr_then_lane;
    maint_ack && maint_wdata == `SRPLL_V_GBL_PWRON |=> ##[1:4] ($rose(maint_req)
      && maint_addr == `SRPLL_OFS_LANE0 && maint_wdata == `SRPLL_V_LANE_NOPLL);
  endproperty
  a_pwr_then_lane: assert property (p_pwr_then_lane) else $error("lane reopen");
endmodule

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the PLL host sequencer and the device together.
// Assumes: Discovery base count shortened to 16 cycles.
// Notes:   Random pin codes and unmapped reads come from a fixed seed.
`timescale 1ns/100ps
`include "srpll_params.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module tb;
  import srpll_pkg::*;
  localparam int DISC = 16;
  logic        clk_sys = 0, arst_n = 0, hard_reset_n = 1, port_power_down = 0;
  logic        boot_active = 0, four_lane_mode = 0, silence_timer_en = 0, in_silent = 0;
  logic        discovery_timer_en = 0, in_discovery = 0, link_wait = 0, link_ready = 0;
  logic        hsel = 1, hwrite = 0, serdes_reset_n_ff, pll_power_on_ff, pll_clock_gate_ff;
  logic        pll_mult_x25_ff, mac_soft_reset_ff, silence_timer_done, discovery_timer_done;
  logic        link_timeout, hreadyout, hresp;
  logic [1:0]  port_speed_pins = 2'h2, htrans = 2'h0, lane_rate_ff;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  lane_rx_en_ff, receive_pll_power_on_ff;
  logic [11:0] lane_tx_en_ff;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [51:0] seen[$];
  int          fail_count = 0, comparisons = 0, seed = 63;
  srpll_if mif ();
  srpll_dev #(.DISC_BASE_CYC(DISC)) srpll_dev_inst (.clk_sys, .arst_n, .mif, .hard_reset_n,
    .port_power_down, .boot_active, .port_speed_pins, .four_lane_mode, .silence_timer_en,
    .in_silent, .discovery_timer_en, .in_discovery, .link_wait, .serdes_reset_n_ff,
    .pll_power_on_ff, .pll_clock_gate_ff, .pll_mult_x25_ff, .lane_tx_en_ff, .lane_rx_en_ff,
    .receive_pll_power_on_ff, .mac_soft_reset_ff, .lane_rate_ff, .silence_timer_done,
    .discovery_timer_done, .link_timeout);
  srpll_host srpll_host_inst (.clk_sys, .arst_n, .mif, .link_ready, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp);
  srpll_properties srpll_properties_inst (.clk_sys, .arst_n, .maint_req(mif.maint_req),
    .maint_wr(mif.maint_wr), .maint_addr(mif.maint_addr), .maint_wdata(mif.maint_wdata),
    .maint_ack(mif.maint_ack), .maint_rdata(mif.maint_rdata));
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (mif.maint_req && mif.maint_ack) seen.push_back({mif.maint_addr, mif.maint_wdata});
  function automatic logic [1:0] exp_rate(input logic [1:0] p, input logic x);
    return p == 2'h2 ? (x ? `SRPLL_RATE_3G125 : `SRPLL_RATE_2G5) : `SRPLL_RATE_1G25;
  endfunction
  function automatic logic [51:0] exp_seq(input int i);
    logic [19:0] ln;
    logic [31:0] g;
    ln = `SRPLL_OFS_LANE0 + 20'(4 * ((i + 2) % 4));
    case (i)
      14: g = `SRPLL_V_GBL_PWROFF;
      15: g = `SRPLL_V_GBL_GATE;
      17: g = `SRPLL_V_GBL_LOAD;
      18, 20: g = `SRPLL_V_GBL_UNGATE;
      19: g = `SRPLL_V_GBL_SRST;
      default: g = `SRPLL_V_GBL_PWRON;
    endcase
    if (i == 0) return {`SRPLL_OFS_MAC, `SRPLL_V_MAC_SRST};
    if (i == 1) return {`SRPLL_OFS_GLOBAL, `SRPLL_V_GBL_OVR};
    if (i < 6) return {ln, `SRPLL_V_LANE_NORX};
    if (i < 10) return {ln, `SRPLL_V_LANE_NOPLL};
    if (i < 14) return {ln, `SRPLL_V_LANE_OFF};
    if (i == 16) return {`SRPLL_OFS_PLLMUL, `SRPLL_V_PLLMUL_X25};
    if (i < 22) return {`SRPLL_OFS_GLOBAL, g};
    if (i < 26) return {ln, `SRPLL_V_LANE_NOPLL};
    if (i < 30) return {ln, `SRPLL_V_LANE_NORX};
    if (i < 34) return {ln, `SRPLL_V_LANE_ON};
    return {`SRPLL_OFS_MAC, `SRPLL_V_MAC_RUN};
  endfunction
  task automatic give_verdict;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk_pll(input logic x);
    `CHK("multiplier", x, pll_mult_x25_ff)
    `CHK("lane rate", exp_rate(port_speed_pins, x), lane_rate_ff)
  endtask
  task automatic run_seq(input logic lr);
    int n;
    link_ready <= lr;
    seen.delete();
    ahb(1'b1, `SRPLL_HOFS_CTRL, 32'h1);
    n = 0;
    do begin
      ahb(1'b0, `SRPLL_HOFS_STATUS, 32'h0);
      n++;
    end while (rd[0] === 1'b1 && n < 100);
    `CHK("status", lr ? 2'h1 : 2'h2, rd[2:1])
    `CHK("writes", lr ? 35 : 0, seen.size())
    for (int i = 0; i < seen.size(); i++)
      `CHK("write", exp_seq(i), seen[i])
    if (lr) begin
      settle(2);
      chk_pll(1'b1);
      `CHK("lanes", {12'h6DB, 8'hFF, 3'h6}, {lane_tx_en_ff, lane_rx_en_ff,
        receive_pll_power_on_ff, pll_power_on_ff, serdes_reset_n_ff, pll_clock_gate_ff})
      `CHK("mac reset", 1'b0, mac_soft_reset_ff)
    end
    $display("test sequence link_ready=%0d done", lr);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    give_verdict();
  end
  initial begin
    settle(4);
    arst_n <= 1;
    settle(2);
    chk_pll(1'b0);
    boot_active <= 1;
    settle(2);
    `CHK("boot serdes reset", 1'b0, serdes_reset_n_ff)
    boot_active <= 0;
    settle(2);
    `CHK("serdes run", 1'b1, serdes_reset_n_ff)
    run_seq(1'b0);
    run_seq(1'b1);
    for (int k = 0; k < 8; k++) begin
      port_speed_pins <= 2'($random(seed));
      settle(2);
      chk_pll(1'b1);
    end
    port_speed_pins <= 2'h2;
    ahb(1'b0, 32'h100 | (32'($random(seed)) & 32'hFC), 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    hard_reset_n <= 0;
    settle(2);
    hard_reset_n <= 1;
    settle(2);
    chk_pll(1'b0);
    run_seq(1'b1);
    port_power_down <= 1;
    settle(2);
    port_power_down <= 0;
    settle(2);
    chk_pll(1'b0);
    silence_timer_en <= 1;
    in_silent <= 1;
    settle(1195);
    `CHK("silence early", 1'b0, silence_timer_done)
    settle(10);
    `CHK("silence done", 1'b1, silence_timer_done)
    in_silent <= 0;
    settle(2);
    `CHK("silence left", 1'b0, silence_timer_done)
    discovery_timer_en <= 1;
    in_discovery <= 1;
    settle(300);
    `CHK("discovery one lane", 1'b0, discovery_timer_done)
    four_lane_mode <= 1;
    settle(9 * DISC - 10);
    `CHK("discovery early", 1'b0, discovery_timer_done)
    settle(20);
    `CHK("discovery done", 1'b1, discovery_timer_done)
    in_discovery <= 0;
    settle(2);
    `CHK("discovery left", 1'b0, discovery_timer_done)
    link_wait <= 1;
    settle(1000);
    `CHK("link timeout", 1'b0, link_timeout)
    $display("test timers done");
    give_verdict();
  end
endmodule
